// *** logic/tcu_pkg.sv ***
package tcu_pkg;

  // ****************************************
  // word layout
  // ****************************************
  localparam int WORD_W = 16;
  localparam int F_PREFIX_LSB = 12;
  localparam int F_SET_LSB = 8;
  localparam int F_MON_LSB = 4;
  localparam int F_LOOP_LSB = 0;
  localparam logic [3:0] CMD_PREFIX = 4'hc;
  localparam logic [3:0] LOOP_ALL = 4'ha;
  localparam logic [15:0] SETTING_ERROR_CODE = 16'hee01;
  localparam logic [15:0] STORE_SETPOINT_COMMAND = 16'hceea;
  localparam logic [15:0] MONITOR_ONLY_DATA = 16'h0000;
  localparam logic [15:0] PARK_WORD = 16'h0000;

  // ****************************************
  // item codes
  // ****************************************
  localparam int NUM_ITEMS = 16;
  localparam logic [3:0] IT_SP = 4'h0;
  localparam logic [3:0] IT_PB = 4'h1;
  localparam logic [3:0] IT_TI = 4'h2;
  localparam logic [3:0] IT_TD = 4'h3;
  localparam logic [3:0] IT_HYST = 4'h4;
  localparam logic [3:0] IT_CYCLE = 4'h5;
  localparam logic [3:0] IT_SHIFT = 4'h6;
  localparam logic [3:0] IT_NONE = 4'h7;
  localparam logic [3:0] IT_MANUAL = 4'h8;
  localparam logic [3:0] IT_HB = 4'ha;
  localparam logic [3:0] MON_PV = 4'h7;
  localparam logic [3:0] MON_MV = 4'h8;
  localparam logic [3:0] MON_STATUS = 4'h9;
  localparam logic [3:0] MON_CURRENT = 4'hb;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_MANUAL_BIT = 1;

  // ****************************************
  // ranges and defaults (binary / bcd)
  // ****************************************
  localparam logic [15:0] VAL_ZERO = 16'h0000;
  localparam logic [15:0] VAL_ONE = 16'h0001;
  localparam logic [15:0] PB_BIN_MAX = 16'h270f;
  localparam logic [15:0] PB_BCD_MAX = 16'h9999;
  localparam logic [15:0] TI_BIN_MAX = 16'h0f9f;
  localparam logic [15:0] TI_BCD_MAX = 16'h3999;
  localparam logic [15:0] CYC_BIN_MAX = 16'h0063;
  localparam logic [15:0] CYC_BCD_MAX = 16'h0099;
  localparam logic [15:0] SHIFT_BIN_MIN = 16'hfc19;
  localparam logic [15:0] SHIFT_BIN_MAX = 16'h270f;
  localparam logic [15:0] HB_BIN_MAX = 16'h01f4;
  localparam logic [15:0] HB_BCD_MAX = 16'h0500;
  localparam logic [15:0] MMV_BIN_MAX = 16'h03e8;
  localparam logic [15:0] MMV_BCD_MAX = 16'h1000;
  localparam logic [15:0] PB_DEF_BIN = 16'h0190;
  localparam logic [15:0] PB_DEF_BCD = 16'h0400;
  localparam logic [15:0] TI_DEF_BIN = 16'h00f0;
  localparam logic [15:0] TI_DEF_BCD = 16'h0240;
  localparam logic [15:0] TD_DEF_BIN = 16'h0028;
  localparam logic [15:0] TD_DEF_BCD = 16'h0040;
  localparam logic [15:0] HYST_DEF = 16'h0008;
  localparam logic [15:0] CYC_DEF_BIN = 16'h0014;
  localparam logic [15:0] CYC_DEF_BCD = 16'h0020;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int NV_WRITE_MS = 60;
  localparam int NV_WRITE_CYCLES_DEF = NV_WRITE_MS * (CLK_HZ / 1000);
  localparam int HOST_TIMEOUT_DEF = 2 * NV_WRITE_CYCLES_DEF;
  localparam int NV_WRITE_LIMIT_DEF = 100_000;

  // one nibble of a word
  function automatic logic [3:0] nib(input logic [15:0] w, input int lsb);
    nib = 4'(w >> lsb);
  endfunction

  // set items that live in nonvolatile memory
  function automatic logic nv_item(input logic [3:0] it);
    nv_item = (it >= IT_PB && it <= IT_SHIFT) || it == IT_HB;
  endfunction

endpackage

// *** logic/tcu_if.sv ***
`timescale 1ns/10ps
interface tcu_if;
  // controller to unit
  logic [15:0] out_word;
  // unit to controller
  logic [15:0] in_word;
  modport device (input out_word, output in_word);
  modport host (output out_word, input in_word);
endinterface

// *** logic/tcu_device.sv ***
`timescale 1ns/10ps
module tcu_device
  import tcu_pkg::*;
#(
  parameter int LOOPS = 4,
  parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // word exchange with the controller
  tcu_if.device link,
  // loop configuration
  input wire logic bcd_mode,
  input wire logic [LOOPS-1:0] fine_range,
  input wire logic signed [15:0] sp_lo,
  input wire logic signed [15:0] sp_hi,
  // loop measurements and state
  input wire logic [15:0] process_value [LOOPS],
  input wire logic [15:0] control_out [LOOPS],
  input wire logic [15:0] heater_current [LOOPS],
  input wire logic [LOOPS-1:0] loop_run,
  input wire logic [LOOPS-1:0] loop_manual,
  input wire logic [LOOPS-1:0] burnout_seen,
  // parameters and alarms
  output logic [15:0] param [LOOPS][NUM_ITEMS],
  output logic [LOOPS-1:0] hb_alarm,
  // nonvolatile store
  output logic nv_we,
  output logic [3:0] nv_item_code,
  output logic [3:0] nv_loop,
  output logic [15:0] nv_data,
  output logic nv_busy
);

  localparam int LW = (LOOPS > 1) ? $clog2(LOOPS) : 1;
  localparam int CW = $clog2(NV_WRITE_CYCLES + 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACKED = 3'b001,
    ST_NVWAIT = 3'b011,
    ST_MONITOR = 3'b010,
    ST_ERROR = 3'b110
  } dev_state_t;

  // ****************************************
  // value checks
  // ****************************************
  function automatic logic bcd_ok(input logic [15:0] w);
    bcd_ok = w[15:12] < 4'ha && w[11:8] < 4'ha && w[7:4] < 4'ha && w[3:0] < 4'ha;
  endfunction

  // bcd with an optional leading f as minus sign
  function automatic logic sbcd_ok(input logic [15:0] w);
    sbcd_ok = bcd_ok(w) || (w[15:12] == 4'hf && bcd_ok({4'h0, w[11:0]}));
  endfunction

  function automatic logic span(input logic [15:0] w, input logic [15:0] lo,
                                input logic [15:0] hi);
    span = w >= lo && w <= hi;
  endfunction

  function automatic logic range_ok(input logic [3:0] it, input logic [15:0] w,
                                    input logic bcd, input logic signed [15:0] lo,
                                    input logic signed [15:0] hi);
    logic ok;
    ok = 1'b0;
    case (it)
      IT_SP: ok = bcd ? sbcd_ok(w) : ($signed(w) >= lo && $signed(w) <= hi);
      IT_PB, IT_HYST: ok = bcd ? bcd_ok(w) && span(w, VAL_ONE, PB_BCD_MAX)
                               : span(w, VAL_ONE, PB_BIN_MAX);
      IT_TI, IT_TD: ok = bcd ? bcd_ok(w) && span(w, VAL_ZERO, TI_BCD_MAX)
                             : span(w, VAL_ZERO, TI_BIN_MAX);
      IT_CYCLE: ok = bcd ? bcd_ok(w) && span(w, VAL_ONE, CYC_BCD_MAX)
                         : span(w, VAL_ONE, CYC_BIN_MAX);
      IT_SHIFT: ok = bcd ? sbcd_ok(w) : ($signed(w) >= $signed(SHIFT_BIN_MIN) &&
                                        $signed(w) <= $signed(SHIFT_BIN_MAX));
      IT_MANUAL: ok = bcd ? bcd_ok(w) && span(w, VAL_ZERO, MMV_BCD_MAX)
                          : span(w, VAL_ZERO, MMV_BIN_MAX);
      IT_HB: ok = bcd ? bcd_ok(w) && span(w, VAL_ZERO, HB_BCD_MAX)
                      : span(w, VAL_ZERO, HB_BIN_MAX);
      default: ok = 1'b0;
    endcase
    range_ok = ok;
  endfunction

  function automatic logic [15:0] default_of(input logic [3:0] it, input logic bcd);
    logic [15:0] v;
    v = VAL_ZERO;
    case (it)
      IT_PB: v = bcd ? PB_DEF_BCD : PB_DEF_BIN;
      IT_TI: v = bcd ? TI_DEF_BCD : TI_DEF_BIN;
      IT_TD: v = bcd ? TD_DEF_BCD : TD_DEF_BIN;
      IT_HYST: v = HYST_DEF;
      IT_CYCLE: v = bcd ? CYC_DEF_BCD : CYC_DEF_BIN;
      default: v = VAL_ZERO;
    endcase
    default_of = v;
  endfunction

  // the decimal point moves, the digits stay: 0.05 in a fine range reads 0.5 after
  // the change; both ranges share the same raw limits, so no clamp is needed
  function automatic logic [15:0] rescale(input logic [15:0] w, input logic to_fine,
                                          input logic bcd);
    logic [15:0] r;
    r = (to_fine || bcd) ? w : w;
    rescale = r;
  endfunction

  // command fields valid for an i/o allocation command
  function automatic logic cmd_ok(input logic [15:0] w, input int loops);
    logic [3:0] s;
    logic [3:0] m;
    logic [3:0] l;
    s = nib(w, F_SET_LSB);
    m = nib(w, F_MON_LSB);
    l = nib(w, F_LOOP_LSB);
    cmd_ok = (s <= IT_MANUAL || s == IT_HB) &&
             m <= MON_CURRENT &&
             l >= 4'h1 && 32'(l) <= loops;
  endfunction

  // ****************************************
  // decode
  // ****************************************
  dev_state_t state;
  logic [15:0] prev_out;
  logic [15:0] cmd;
  logic [15:0] resp;
  logic [CW-1:0] nv_cnt;
  logic echo_after_nv;
  logic [LOOPS-1:0] fine_prev;
  logic [LOOPS-1:0] manual_prev;
  logic [15:0] mon_val;
  logic changed;
  logic is_cmd;
  logic take_data;
  logic data_ok;
  logic do_write;
  logic [3:0] set_it;
  logic [LW-1:0] cli;

  assign changed = link.out_word != prev_out;
  assign is_cmd = nib(link.out_word, F_PREFIX_LSB) == CMD_PREFIX;
  assign set_it = nib(cmd, F_SET_LSB);
  assign cli = LW'(nib(cmd, F_LOOP_LSB) - 4'h1);
  // a word without the prefix is data for the accepted command
  assign take_data = changed && !is_cmd && (state == ST_ACKED || state == ST_MONITOR);
  assign data_ok = range_ok(set_it, link.out_word, bcd_mode, sp_lo, sp_hi);
  assign do_write = take_data && set_it != IT_NONE && data_ok;
  assign link.in_word = resp;
  assign nv_busy = state == ST_NVWAIT;

  // monitor item selection
  always_comb begin
    mon_val = VAL_ZERO;
    case (nib(cmd, F_MON_LSB))
      MON_PV: mon_val = process_value[cli];
      MON_MV: mon_val = control_out[cli];
      MON_STATUS: begin
        mon_val[STAT_RUN_BIT] = loop_run[cli];
        mon_val[STAT_MANUAL_BIT] = loop_manual[cli];
      end
      MON_CURRENT: mon_val = heater_current[cli];
      default: mon_val = param[cli][nib(cmd, F_MON_LSB)];
    endcase
  end

  // ****************************************
  // handshake state machine
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prev_out <= VAL_ZERO;
    end else begin
      prev_out <= link.out_word;
    end
  end

  // changes arriving during a nonvolatile write are dropped; the controller waits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cmd <= VAL_ZERO;
      resp <= VAL_ZERO;
      nv_cnt <= '0;
      echo_after_nv <= 1'b0;
      nv_we <= 1'b0;
      nv_item_code <= 4'h0;
      nv_loop <= 4'h0;
      nv_data <= VAL_ZERO;
    end else begin
      nv_we <= 1'b0;
      if (state == ST_NVWAIT) begin
        nv_cnt <= nv_cnt + 1'b1;
        if (nv_cnt == CW'(NV_WRITE_CYCLES - 1)) begin
          resp <= echo_after_nv ? cmd : mon_val;
          state <= echo_after_nv ? ST_IDLE : ST_MONITOR;
        end
      end else if (changed && is_cmd) begin
        cmd <= link.out_word;
        if (link.out_word == STORE_SETPOINT_COMMAND) begin
          nv_we <= 1'b1;
          nv_item_code <= IT_SP;
          nv_loop <= LOOP_ALL;
          nv_cnt <= '0;
          echo_after_nv <= 1'b1;
          state <= ST_NVWAIT;
        end else if (cmd_ok(link.out_word, LOOPS)) begin
          resp <= link.out_word;
          state <= ST_ACKED;
        end else begin
          resp <= SETTING_ERROR_CODE;
          state <= ST_ERROR;
        end
      end else if (take_data) begin
        if (set_it == IT_NONE) begin
          state <= ST_MONITOR;
        end else if (!data_ok) begin
          resp <= SETTING_ERROR_CODE;
          state <= ST_ERROR;
        end else if (nv_item(set_it) && param[cli][set_it] != link.out_word) begin
          nv_we <= 1'b1;
          nv_item_code <= set_it;
          nv_loop <= nib(cmd, F_LOOP_LSB);
          nv_data <= link.out_word;
          nv_cnt <= '0;
          echo_after_nv <= 1'b0;
          state <= ST_NVWAIT;
        end else begin
          state <= ST_MONITOR;
        end
      end else if (state == ST_MONITOR) begin
        resp <= mon_val;
      end
    end
  end

  // ****************************************
  // parameter store
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fine_prev <= fine_range;
      manual_prev <= loop_manual;
    end else begin
      fine_prev <= fine_range;
      manual_prev <= loop_manual;
    end
  end

  // set point and manual value are plain registers; only the store path reaches nv
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int l = 0; l < LOOPS; l++) begin
        for (int i = 0; i < NUM_ITEMS; i++) begin
          param[l][i] <= default_of(4'(i), bcd_mode);
        end
      end
    end else begin
      for (int l = 0; l < LOOPS; l++) begin
        if (fine_range[l] != fine_prev[l]) begin
          param[l][IT_SHIFT] <= rescale(param[l][IT_SHIFT], fine_range[l], bcd_mode);
        end
        if (loop_manual[l] && !manual_prev[l]) begin
          param[l][IT_MANUAL] <= control_out[l];
        end
      end
      if (do_write) begin
        param[cli][set_it] <= link.out_word;
      end
    end
  end

  // ****************************************
  // burnout alarm latch
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hb_alarm <= '0;
    end else begin
      for (int l = 0; l < LOOPS; l++) begin
        if (do_write && set_it == IT_HB && cli == LW'(l)) begin
          if (link.out_word == VAL_ZERO) begin
            hb_alarm[l] <= 1'b0;
          end else if (link.out_word == (bcd_mode ? HB_BCD_MAX : HB_BIN_MAX)) begin
            hb_alarm[l] <= 1'b1;
          end
        end else if (burnout_seen[l] && param[l][IT_HB] != VAL_ZERO &&
                     param[l][IT_HB] != (bcd_mode ? HB_BCD_MAX : HB_BIN_MAX)) begin
          hb_alarm[l] <= 1'b1;
        end
      end
    end
  end

endmodule

// *** logic/tcu_host.sv ***
`timescale 1ns/10ps
module tcu_host
  import tcu_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = HOST_TIMEOUT_DEF,
  parameter int NV_WRITE_LIMIT = NV_WRITE_LIMIT_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // word exchange with the unit
  tcu_if.host link,
  // user request
  input wire logic req,
  input wire logic [15:0] req_cmd,
  input wire logic [15:0] req_data,
  // user answer
  output logic busy,
  output logic done,
  output logic error,
  output logic timeout,
  output logic refused,
  output logic [15:0] result,
  output logic [16:0] wear_count
);

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_ACKWAIT = 2'b01,
    H_DONEWAIT = 2'b11
  } host_state_t;

  host_state_t state;
  logic [15:0] out_reg;
  logic [15:0] cmd;
  logic [15:0] data;
  logic [TW-1:0] wait_cnt;
  logic nv_req;
  logic worn;

  assign link.out_word = out_reg;
  assign busy = state != H_IDLE;
  assign nv_req = nv_item(nib(req_cmd, F_SET_LSB)) || req_cmd == STORE_SETPOINT_COMMAND;
  assign worn = 32'(wear_count) >= NV_WRITE_LIMIT;

  // ****************************************
  // request sequencer
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= H_IDLE;
      out_reg <= PARK_WORD;
      cmd <= VAL_ZERO;
      data <= VAL_ZERO;
      wait_cnt <= '0;
      done <= 1'b0;
      error <= 1'b0;
      timeout <= 1'b0;
      refused <= 1'b0;
      result <= VAL_ZERO;
      wear_count <= '0;
    end else begin
      done <= 1'b0;
      error <= 1'b0;
      timeout <= 1'b0;
      refused <= 1'b0;
      wait_cnt <= wait_cnt + 1'b1;
      case (state)
        H_IDLE: begin
          if (req && nv_req && worn) begin
            refused <= 1'b1;
          end else if (req) begin
            if (nv_req) begin
              wear_count <= wear_count + 1'b1;
            end
            cmd <= req_cmd;
            // monitor only forces zero write data
            data <= (nib(req_cmd, F_SET_LSB) == IT_NONE) ? MONITOR_ONLY_DATA : req_data;
            out_reg <= req_cmd;
            wait_cnt <= '0;
            state <= H_ACKWAIT;
          end
        end
        H_ACKWAIT: begin
          if (wait_cnt == '0) begin
            // the unit takes the new word at this edge, so in_word is still the old answer
            state <= H_ACKWAIT;
          end else if (link.in_word == cmd) begin
            wait_cnt <= '0;
            if (cmd == STORE_SETPOINT_COMMAND) begin
              result <= link.in_word;
              done <= 1'b1;
              state <= H_IDLE;
            end else begin
              out_reg <= data;
              state <= H_DONEWAIT;
            end
          end else if (link.in_word == SETTING_ERROR_CODE) begin
            // park so the same command can be sent again as a fresh change
            out_reg <= PARK_WORD;
            error <= 1'b1;
            state <= H_IDLE;
          end else if (wait_cnt == TW'(TIMEOUT_CYCLES - 1)) begin
            out_reg <= PARK_WORD;
            timeout <= 1'b1;
            state <= H_IDLE;
          end
        end
        H_DONEWAIT: begin
          if (link.in_word == SETTING_ERROR_CODE) begin
            error <= 1'b1;
            state <= H_IDLE;
          end else if (link.in_word != cmd) begin
            result <= link.in_word;
            done <= 1'b1;
            state <= H_IDLE;
          end else if (wait_cnt == TW'(TIMEOUT_CYCLES - 1)) begin
            timeout <= 1'b1;
            state <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

endmodule

// *** tb/tcu_link_props.sv ***
`timescale 1ns/10ps
module tcu_link_props
  import tcu_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = 20
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // link words
  input wire logic [15:0] out_word,
  input wire logic [15:0] in_word
);
  // ********
  // link word checks
  // ********
  localparam int DONE_MAX = NV_WRITE_CYCLES + 3;
  logic [15:0] prev_out;
  logic [15:0] last_cmd;
  logic take;
  logic cmd_take;
  logic is_store;
  logic good_cmd;

  // a word is taken where it differs from the last edge
  assign take = out_word != prev_out;
  assign cmd_take = take && out_word[15:12] == CMD_PREFIX;
  assign is_store = cmd_take && out_word == STORE_SETPOINT_COMMAND;
  // listed codes only; loops 1 to 4, so all-loops is refused here
  assign good_cmd = (out_word[11:8] <= IT_MANUAL || out_word[11:8] == IT_HB) &&
    out_word[7:4] <= MON_CURRENT && out_word[3:0] != 4'h0 && out_word[3:0] <= 4'h4;

  // last word and last command, kept across data words
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prev_out <= PARK_WORD;
      last_cmd <= PARK_WORD;
    end else begin
      prev_out <= out_word;
      if (cmd_take) begin
        last_cmd <= out_word;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_echo;
    cmd_take && good_cmd |=> in_word == last_cmd;
  endproperty
  a_echo: assert property (p_echo) else $error("command not echoed");

  property p_bad_code;
    cmd_take && !good_cmd && !is_store |=> in_word == SETTING_ERROR_CODE;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code not refused");

  property p_err_stands;
    in_word == SETTING_ERROR_CODE && !cmd_take |=> in_word == SETTING_ERROR_CODE;
  endproperty
  a_err_stands: assert property (p_err_stands) else $error("error word dropped");

  property p_echo_stands;
    in_word == last_cmd && out_word == last_cmd && !take |=> $stable(in_word);
  endproperty
  a_echo_stands: assert property (p_echo_stands) else $error("echo moved");

  property p_data_done;
    take && out_word[15:12] != CMD_PREFIX && prev_out == last_cmd && in_word == last_cmd
      |-> ##[1:DONE_MAX] in_word != last_cmd;
  endproperty
  a_data_done: assert property (p_data_done) else $error("data not completed");

  property p_mon_only;
    take && out_word == MONITOR_ONLY_DATA && prev_out[15:8] == {CMD_PREFIX, IT_NONE} &&
      in_word == prev_out |-> ##2 in_word != last_cmd;
  endproperty
  a_mon_only: assert property (p_mon_only) else $error("monitor only slow");

  property p_nv_min;
    is_store |=> (in_word != STORE_SETPOINT_COMMAND) [*8];
  endproperty
  a_nv_min: assert property (p_nv_min) else $error("store acked early");

  property p_store_ack;
    is_store |-> ##[9:DONE_MAX] in_word == STORE_SETPOINT_COMMAND;
  endproperty
  a_store_ack: assert property (p_store_ack) else $error("store not acked");
endmodule

// *** tb/temp_ctrl_param_command_decoder_tb.sv ***
`timescale 1ns/10ps
module temp_ctrl_param_command_decoder_tb;
  import tcu_pkg::*;
  // ********
  // bench signals
  // ********
  localparam int NVW = 20;
  typedef struct packed {
    logic [1:0] kind;
    logic [15:0] val;
  } note_t;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req = 1'b0;
  logic [15:0] req_cmd = 16'h0000;
  logic [15:0] req_data = 16'h0000;
  logic [3:0] fine_range = 4'h4;
  logic [3:0] loop_manual = 4'h0;
  logic [3:0] burnout_seen = 4'hf;
  logic [3:0] loop_run, hb_alarm, nv_item_code, nv_loop;
  logic [15:0] pv [4], mv [4], hc [4], bad [8], defs [8], mi [8];
  logic [15:0] param [4][16];
  logic nv_we, nv_busy, busy, done, error, timeout, refused;
  logic [15:0] nv_data, result, v;
  logic [16:0] wear_count;
  int mismatches = 0, check_count = 0, answers = 0, nv_pulses = 0, wait_n, n0;
  note_t notes [$];

  tcu_if link ();
  tcu_device #(.LOOPS(4), .NV_WRITE_CYCLES(NVW)) u_tcu_device (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .link(link), .bcd_mode(1'b0), .fine_range(fine_range),
    .sp_lo(-16'sd100), .sp_hi(16'sd1000), .process_value(pv), .control_out(mv),
    .heater_current(hc), .loop_run(loop_run), .loop_manual(loop_manual),
    .burnout_seen(burnout_seen), .param(param), .hb_alarm(hb_alarm), .nv_we(nv_we),
    .nv_item_code(nv_item_code), .nv_loop(nv_loop), .nv_data(nv_data), .nv_busy(nv_busy));
  tcu_host #(.TIMEOUT_CYCLES(60), .NV_WRITE_LIMIT(8)) u_tcu_host (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .link(link), .req(req), .req_cmd(req_cmd), .req_data(req_data),
    .busy(busy), .done(done), .error(error), .timeout(timeout), .refused(refused),
    .result(result), .wear_count(wear_count));
  tcu_link_props #(.NV_WRITE_CYCLES(NVW)) u_tcu_link_props (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .out_word(link.out_word), .in_word(link.in_word));

  always #12.5 ref_clk = ~ref_clk;

  function automatic logic [15:0] cw(input logic [3:0] s, input logic [3:0] m,
                                      input logic [3:0] l);
    return {CMD_PREFIX, s, m, l};
  endfunction

  task automatic fail(input string msg);
    mismatches++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask

  task automatic check_word(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp) fail($sformatf("word %h, want %h", got, exp));
  endtask

  task automatic check_answer(input note_t n);
    logic [1:0] got;
    got = done ? 2'd0 : error ? 2'd1 : refused ? 2'd2 : 2'd3;
    check_count++;
    if (got !== n.kind || (n.kind == 2'd0 && result !== n.val))
      fail($sformatf("answer %0d %h, want %0d %h", got, result, n.kind, n.val));
  endtask

  // note the expectation, pulse the request, then wait for its answer
  task automatic ask(input logic [15:0] cmd, input logic [15:0] data,
                     input logic [1:0] kind, input logic [15:0] val);
    int start;
    start = answers;
    notes.push_back({kind, val});
    req <= 1'b1;
    req_cmd <= cmd;
    req_data <= data;
    @(posedge ref_clk);
    req <= 1'b0;
    wait_n = 0;
    while (answers == start && wait_n < 200) begin
      @(posedge ref_clk);
      wait_n++;
    end
    if (answers == start) fail("no answer");
    @(posedge ref_clk);
  endtask

  // answer watcher: oldest note against each answer pulse
  always @(posedge ref_clk) begin
    if (nv_we === 1'b1) nv_pulses++;
    if (done === 1'b1 || error === 1'b1 || refused === 1'b1 || timeout === 1'b1) begin
      answers++;
      if (notes.size() == 0) fail("answer without note");
      else check_answer(notes.pop_front());
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog, far above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail("watchdog");
    summarize();
  end

  // ********
  // tests
  // ********
  initial begin
    void'($urandom(98));
    loop_run = 4'($urandom);
    foreach (pv[i]) begin
      pv[i] = 16'($urandom) & 16'h0fff;
      mv[i] = 16'($urandom) & 16'h0fff;
      hc[i] = 16'($urandom) & 16'h0fff;
    end
    mi = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6, 16'ha};
    defs = '{16'h0, PB_DEF_BIN, TI_DEF_BIN, TD_DEF_BIN, HYST_DEF, CYC_DEF_BIN, 16'h0, 16'h0};
    bad = '{cw(4'h9, 4'h7, 4'h1), cw(4'hb, 4'h7, 4'h1), cw(4'hc, 4'hd, 4'h1),
      cw(4'hd, 4'hc, 4'h1), cw(4'hf, 4'hc, 4'h1), cw(4'h0, 4'h7, 4'h0),
      cw(4'h0, 4'h7, 4'h5), cw(4'h0, 4'hc, 4'h1)};
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    foreach (mi[i]) ask(cw(IT_NONE, mi[i][3:0], 4'h1), MONITOR_ONLY_DATA, 2'd0, defs[i]);
    check_word(17'(hb_alarm), 17'h0);
    ask(cw(IT_NONE, MON_PV, 4'h2), MONITOR_ONLY_DATA, 2'd0, pv[1]);
    ask(cw(IT_NONE, MON_MV, 4'h2), MONITOR_ONLY_DATA, 2'd0, mv[1]);
    ask(cw(IT_NONE, MON_STATUS, 4'h3), 16'h0, 2'd0, {14'h0, 1'b0, loop_run[2]});
    ask(cw(IT_NONE, MON_CURRENT, 4'h4), 16'h0, 2'd0, hc[3]);
    $display("test monitor finished");
    foreach (bad[i]) ask(bad[i], 16'h0, 2'd1, 16'h0);
    $display("test refusal finished");
    v = 16'($urandom_range(32'h270f, 32'h0200));
    ask(cw(IT_PB, IT_PB, 4'h1), v, 2'd0, v);
    check_word(17'(wait_n >= NVW), 17'h1);
    ask(cw(IT_PB, IT_PB, 4'h1), 16'h0000, 2'd1, 16'h0);
    ask(cw(IT_PB, IT_PB, 4'h1), 16'h2710, 2'd1, 16'h0);
    ask(cw(IT_NONE, IT_PB, 4'h1), 16'h0, 2'd0, v);
    check_word(17'(param[0][1]), 17'(v));
    $display("test band finished");
    n0 = nv_pulses;
    ask(cw(IT_SP, MON_PV, 4'h1), 16'h0100, 2'd0, pv[0]);
    check_word(17'(nv_pulses - n0), 17'h0);
    ask(STORE_SETPOINT_COMMAND, 16'h0, 2'd0, STORE_SETPOINT_COMMAND);
    check_word(17'(nv_pulses - n0), 17'h1);
    check_word(17'(nv_loop), 17'ha);
    $display("test set point finished");
    ask(cw(IT_HB, IT_HB, 4'h2), HB_BIN_MAX, 2'd0, HB_BIN_MAX);
    check_word(17'(hb_alarm), 17'h2);
    ask(cw(IT_HB, IT_HB, 4'h2), 16'h0, 2'd0, 16'h0);
    check_word(17'(hb_alarm), 17'h0);
    $display("test burnout finished");
    loop_manual <= 4'h4;
    ask(cw(IT_SHIFT, IT_SHIFT, 4'h3), 16'h0005, 2'd0, 16'h0005);
    check_word(17'(param[2][8]), 17'(mv[2]));
    fine_range <= 4'h0;
    repeat (3) @(posedge ref_clk);
    check_word(17'(param[2][6]), 17'h0005);
    $display("test manual and shift finished");
    ask(cw(IT_TI, IT_TI, 4'h1), 16'h0064, 2'd0, 16'h0064);
    check_word(wear_count, 17'h8);
    ask(cw(IT_TD, IT_TD, 4'h1), 16'h0001, 2'd2, 16'h0);
    $display("test wear finished");
    summarize();
  end
endmodule
